// *** logic/nprc_map.svh ***
/*
 * Constants of the NAND page-read host sequencer: clock rate, bus timing, command bytes.
 * Assumes it is included by bare name from the design file.
 */
`ifndef NPRC_MAP_SVH
`define NPRC_MAP_SVH

`define NPRC_CLK_MHZ        250
// least times round up to whole cycles
`define NPRC_CYC(ns)        (((ns) * `NPRC_CLK_MHZ + 999) / 1000)
`define NPRC_T_WP_NS        12
`define NPRC_T_WH_NS        10
`define NPRC_T_RP_NS        24
`define NPRC_T_REH_NS       10
`define NPRC_T_WB_NS        100
`define NPRC_T_CCS_NS       200
`define NPRC_T_PAGE_READ_NS 50000
`define NPRC_WP_CYC         `NPRC_CYC(`NPRC_T_WP_NS)
`define NPRC_WH_CYC         `NPRC_CYC(`NPRC_T_WH_NS)
`define NPRC_RP_CYC         `NPRC_CYC(`NPRC_T_RP_NS)
`define NPRC_REH_CYC        `NPRC_CYC(`NPRC_T_REH_NS)
`define NPRC_WB_CYC         `NPRC_CYC(`NPRC_T_WB_NS)
`define NPRC_CCS_CYC        `NPRC_CYC(`NPRC_T_CCS_NS)
`define NPRC_PAGE_READ_CYC  `NPRC_CYC(`NPRC_T_PAGE_READ_NS)

`define NPRC_CMD_READ       8'h00
`define NPRC_CMD_PAGE       8'h30
`define NPRC_CMD_CSEQ       8'h31
`define NPRC_CMD_MPQ        8'h32
`define NPRC_CMD_CLAST      8'h3F
`define NPRC_CMD_COLCHG     8'h05
`define NPRC_CMD_COLENH     8'h06
`define NPRC_CMD_COLEND     8'hE0
`define NPRC_CMD_ROWCHG     8'h85
`define NPRC_CMD_STAT       8'h70
`define NPRC_CMD_STENH      8'h78
`define NPRC_CMD_RESET      8'hFF

`endif

// *** logic/nprc_pkg.sv ***
/*
 * Types of the NAND page-read host sequencer: operations, die modes, states, request.
 * Assumes nprc_map.svh is on the include path.
 */
package nprc_pkg;
	typedef enum logic [3:0] {
		OP_PAGE = 4'h0, OP_MPQ = 4'h1, OP_CSEQ = 4'h2, OP_CRAND = 4'h3,
		OP_CLAST = 4'h4, OP_RMODE = 4'h5, OP_STAT = 4'h6, OP_STENH = 4'h7,
		OP_COLCHG = 4'h8, OP_COLENH = 4'h9, OP_ROWCHG = 4'hA, OP_RESET = 4'hB
	} nprc_op_t;
	typedef enum logic [1:0] {
		M_READY = 2'h0, M_CACHE = 2'h1, M_MPCACHE = 2'h2, M_MPQ = 2'h3
	} nprc_mode_t;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_STEP = 4'h1, S_LO = 4'h2, S_HI = 4'h3, S_WB = 4'h4,
		S_RB = 4'h5, S_GAP = 4'h6, S_RWAIT = 4'h7, S_RLO = 4'h8, S_RHI = 4'h9
	} nprc_st_t;
	typedef enum logic [1:0] {
		K_CMD = 2'h0, K_ADDR = 2'h1, K_WAIT = 2'h2, K_END = 2'h3
	} nprc_kind_t;
	typedef struct packed {
		nprc_kind_t  kind;
		logic [7:0]  data;
	} nprc_item_t;
	// addr bytes 0-1 column, 2-4 row; cnt = bytes to read afterwards
	typedef struct packed {
		nprc_op_t    op;
		logic [39:0] addr;
		logic [15:0] cnt;
	} nprc_req_t;
endpackage : nprc_pkg

// *** logic/nprc_host.sv ***
/*
 * Host-side read sequencer for a NAND die: issues page, cache, multi-plane, status and
 * column-change command sequences on the multiplexed bus and drains read bytes into a FIFO.
 * Assumes a single die on the target, ready/busy pin with external pull-up, one 250 MHz clock.
 */
`timescale 1ns/1ps
`include "nprc_map.svh"

module nprc_fifo #(
	parameter int unsigned W = 8,
	parameter int unsigned D = 4
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);
	localparam int unsigned AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0]         wp;
		logic [AW:0]         rp;
	} nprc_fifo_st_t;
	nprc_fifo_st_t q, d;
	logic full, empty;

	assign full        = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
	assign empty       = (q.wp == q.rp);
	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign o_out_data  = q.mem[q.rp[AW-1:0]];

	always_comb begin
		d = q;
		if (i_in_valid && !full) begin
			d.mem[q.wp[AW-1:0]] = i_in_data;
			d.wp = q.wp + 1'b1;
		end
		if (i_out_ready && !empty) begin
			d.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // nprc_fifo

module nprc_host #(
	parameter int unsigned PAGE_READ_CYC = `NPRC_PAGE_READ_CYC,
	parameter int unsigned FIFO_DEPTH    = 4
) (
	input  wire logic               i_clk,
	input  wire logic               i_reset_n,
	input  wire logic               i_req_valid,
	output logic                    o_req_ready,
	input  wire nprc_pkg::nprc_req_t i_req,
	output logic                    o_refused,
	output logic                    o_timeout,
	output logic                    o_busy,
	output nprc_pkg::nprc_mode_t    o_mode,
	output logic                    o_rd_valid,
	input  wire logic               i_rd_ready,
	output logic [7:0]              o_rd_data,
	output logic                    o_ce_n,
	output logic                    o_cle,
	output logic                    o_ale,
	output logic                    o_we_n,
	output logic                    o_re_n,
	output logic [7:0]              o_dq_o,
	output logic                    o_dq_oe_n,
	input  wire logic [7:0]         i_dq,
	input  wire logic               i_rb_n
);
	import nprc_pkg::*;

	localparam logic [15:0] WP_C  = 16'(`NPRC_WP_CYC);
	localparam logic [15:0] WH_C  = 16'(`NPRC_WH_CYC);
	localparam logic [15:0] RP_C  = 16'(`NPRC_RP_CYC);
	localparam logic [15:0] REH_C = 16'(`NPRC_REH_CYC);
	localparam logic [15:0] WB_C  = 16'(`NPRC_WB_CYC);
	localparam logic [15:0] CCS_C = 16'(`NPRC_CCS_CYC);
	localparam logic [15:0] TMO_C = 16'(PAGE_READ_CYC);

	typedef struct packed {
		nprc_st_t    state;
		nprc_op_t    op;
		nprc_mode_t  mode;
		logic [3:0]  step;
		logic [15:0] tmr;
		logic [15:0] cnt;
		logic [39:0] addr;
		logic        mp;
		logic        sel_need;
		logic        restore;
		logic [2:0]  rb;
		logic [7:0]  dq1;
		logic [7:0]  dq2;
		logic [7:0]  dq3;
		logic        ce_n;
		logic        cle;
		logic        ale;
		logic        we_n;
		logic        re_n;
		logic [7:0]  dq_o;
		logic        dq_oe_n;
		logic        refused;
		logic        tmo;
	} nprc_host_st_t;

	nprc_host_st_t q, d;
	logic [1:0]    rst_sync;
	logic          rst_n;
	logic          push;
	logic          fifo_ready;
	logic          rb_hi;
	logic          fire;
	nprc_item_t    it;

	function automatic nprc_item_t seq_item(nprc_op_t op, logic [3:0] s, logic [39:0] a);
		nprc_item_t r;
		logic [3:0] bi;
		logic [7:0] fin;
		bi = (op == OP_STENH) ? s + 4'h1 : s - 4'h1;
		fin = (op == OP_MPQ) ? `NPRC_CMD_MPQ : (op == OP_CRAND) ? `NPRC_CMD_CSEQ : `NPRC_CMD_PAGE;
		r.kind = K_END;
		r.data = 8'(a >> {bi, 3'b000});
		case (op)
			OP_PAGE, OP_MPQ, OP_CRAND: begin
				if (s == 4'h0) r = '{K_CMD, `NPRC_CMD_READ};
				else if (s <= 4'h5) r.kind = K_ADDR;
				else if (s == 4'h6) r = '{K_CMD, fin};
				else if (s == 4'h7) r.kind = K_WAIT;
			end
			OP_CSEQ, OP_CLAST, OP_RESET: begin
				if (s == 4'h0) begin
					r.kind = K_CMD;
					r.data = (op == OP_CSEQ) ? `NPRC_CMD_CSEQ :
						(op == OP_CLAST) ? `NPRC_CMD_CLAST : `NPRC_CMD_RESET;
				end else if (s == 4'h1) r.kind = K_WAIT;
			end
			OP_RMODE: if (s == 4'h0) r = '{K_CMD, `NPRC_CMD_READ};
			OP_STAT:  if (s == 4'h0) r = '{K_CMD, `NPRC_CMD_STAT};
			// enhanced status names the die by its row address
			OP_STENH: begin
				if (s == 4'h0) r = '{K_CMD, `NPRC_CMD_STENH};
				else if (s <= 4'h3) r.kind = K_ADDR;
			end
			OP_COLCHG: begin
				if (s == 4'h0) r = '{K_CMD, `NPRC_CMD_COLCHG};
				else if (s <= 4'h2) r.kind = K_ADDR;
				else if (s == 4'h3) r = '{K_CMD, `NPRC_CMD_COLEND};
			end
			// enhanced column change picks the plane register
			OP_COLENH: begin
				if (s == 4'h0) r = '{K_CMD, `NPRC_CMD_COLENH};
				else if (s <= 4'h5) r.kind = K_ADDR;
				else if (s == 4'h6) r = '{K_CMD, `NPRC_CMD_COLEND};
			end
			// row and column change, no data input path here
			OP_ROWCHG: begin
				if (s == 4'h0) r = '{K_CMD, `NPRC_CMD_ROWCHG};
				else if (s <= 4'h5) r.kind = K_ADDR;
			end
			default: r.kind = K_END;
		endcase
		return r;
	endfunction

	function automatic logic op_ok(nprc_op_t op, nprc_mode_t m, logic sel, logic rst, logic dat);
		logic ok;
		logic stat;
		stat = (op == OP_STAT) || (op == OP_STENH);
		case (m)
			M_READY: ok = 1'b1;
			M_CACHE: ok = stat || op inside {OP_RMODE, OP_CSEQ, OP_CRAND, OP_COLCHG,
				OP_CLAST, OP_RESET};
			// multi-plane cache-busy adds plane queue and plane select
			M_MPCACHE: ok = stat || op inside {OP_RMODE, OP_CSEQ, OP_CRAND, OP_COLCHG,
				OP_CLAST, OP_RESET, OP_MPQ, OP_COLENH};
			// after a plane queue only more plane queues, the read finishers, status and reset continue
			M_MPQ: ok = stat || op inside {OP_MPQ, OP_PAGE, OP_CRAND, OP_RESET};
			default: ok = 1'b0;
		endcase
		// no data until a plane register is selected
		if (dat && sel && !stat && op != OP_COLENH) ok = 1'b0;
		// status output must be turned back to data first
		if (dat && rst && !stat && !(op inside {OP_RMODE, OP_COLCHG, OP_COLENH})) ok = 1'b0;
		return ok;
	endfunction

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// pin counts as ready once second and third stage both read high
	assign rb_hi       = q.rb[2] && q.rb[1];
	assign it          = seq_item(q.op, q.step, q.addr);
	assign o_req_ready = (q.state == S_IDLE);
	assign fire        = i_req_valid && o_req_ready;
	assign push        = (q.state == S_RLO) && (q.tmr == 16'h0000);

	always_comb begin
		d = q;
		d.refused = 1'b0;
		d.tmo = 1'b0;
		d.rb = {q.rb[1:0], i_rb_n};
		d.dq1 = i_dq;
		d.dq2 = q.dq1;
		d.dq3 = q.dq2;
		case (q.state)
			S_IDLE: begin
				if (i_req_valid) begin
					// refuse what the die would ignore
					if (op_ok(i_req.op, q.mode, q.sel_need, q.restore, i_req.cnt != 16'h0000)) begin
						d.op = i_req.op;
						d.addr = i_req.addr;
						d.cnt = (i_req.op inside {OP_STAT, OP_STENH}) ? 16'h0001 : i_req.cnt;
						d.step = 4'h0;
						d.ce_n = 1'b0;
						d.state = S_STEP;
					end else begin
						d.refused = 1'b1;
					end
				end
			end
			S_STEP: begin
				case (it.kind)
					K_CMD, K_ADDR: begin
						d.cle = (it.kind == K_CMD);
						d.ale = (it.kind == K_ADDR);
						d.dq_o = it.data;
						d.dq_oe_n = 1'b0;
						d.we_n = 1'b0;
						d.tmr = WP_C - 16'h0001;
						d.state = S_LO;
					end
					K_WAIT: begin
						d.tmr = WB_C - 16'h0001;
						d.state = S_WB;
					end
					default: begin
						case (q.op)
							// multi-plane flag comes from the plane queue
							OP_PAGE: begin
								d.mode = M_READY;
								d.mp = (q.mode == M_MPQ);
								d.sel_need = 1'b0;
							end
							OP_MPQ: begin
								d.mode = M_MPQ;
								d.mp = 1'b1;
							end
							// after cache busy the die is in cache-busy state
							OP_CSEQ, OP_CRAND: begin
								d.mode = q.mp ? M_MPCACHE : M_CACHE;
								d.sel_need = q.mp;
							end
							// cache-last ends the sequence ready, still needing a plane select after multi-plane
							OP_CLAST: begin
								d.mode = M_READY;
								d.sel_need = q.mp;
							end
							OP_RESET: begin
								d.mode = M_READY;
								d.mp = 1'b0;
								d.sel_need = 1'b0;
								d.restore = 1'b0;
							end
							OP_STAT, OP_STENH: d.restore = 1'b1;
							// read mode turns the die back to data output
							OP_RMODE, OP_COLCHG: d.restore = 1'b0;
							OP_COLENH: begin
								d.restore = 1'b0;
								d.sel_need = 1'b0;
							end
							default: d.mode = q.mode;
						endcase
						if (q.cnt != 16'h0000) begin
							d.tmr = CCS_C - 16'h0001;
							d.state = S_GAP;
						end else begin
							d.ce_n = 1'b1;
							d.state = S_IDLE;
						end
					end
				endcase
			end
			S_LO: begin
				d.tmr = q.tmr - 16'h0001;
				if (q.tmr == 16'h0000) begin
					d.we_n = 1'b1;
					d.tmr = WH_C - 16'h0001;
					d.state = S_HI;
				end
			end
			S_HI: begin
				d.tmr = q.tmr - 16'h0001;
				if (q.tmr == 16'h0000) begin
					d.cle = 1'b0;
					d.ale = 1'b0;
					d.dq_oe_n = 1'b1;
					d.step = q.step + 4'h1;
					d.state = S_STEP;
				end
			end
			S_WB: begin
				d.tmr = q.tmr - 16'h0001;
				if (q.tmr == 16'h0000) begin
					// busy wait counts up from zero toward the timeout
					d.tmr = 16'h0000;
					d.state = S_RB;
				end
			end
			// nothing is issued while the pin shows busy, until the busy wait reaches the timeout
			S_RB: begin
				d.tmr = q.tmr + 16'h0001;
				if (rb_hi || q.tmr == TMO_C - 16'h0001) begin
					d.tmo = !rb_hi;
					d.step = q.step + 4'h1;
					d.state = S_STEP;
				end
			end
			S_GAP: begin
				d.tmr = q.tmr - 16'h0001;
				if (q.tmr == 16'h0000) begin
					d.state = S_RWAIT;
				end
			end
			// back-pressure: a byte is strobed only when the FIFO has room
			S_RWAIT: begin
				if (fifo_ready) begin
					d.re_n = 1'b0;
					d.tmr = RP_C - 16'h0001;
					d.state = S_RLO;
				end
			end
			S_RLO: begin
				d.tmr = q.tmr - 16'h0001;
				if (q.tmr == 16'h0000) begin
					d.re_n = 1'b1;
					d.cnt = q.cnt - 16'h0001;
					d.tmr = REH_C - 16'h0001;
					d.state = S_RHI;
				end
			end
			S_RHI: begin
				d.tmr = q.tmr - 16'h0001;
				if (q.tmr == 16'h0000) begin
					d.ce_n = (q.cnt == 16'h0000);
					d.state = (q.cnt == 16'h0000) ? S_IDLE : S_RWAIT;
				end
			end
			default: d.state = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{state: S_IDLE, op: OP_RESET, mode: M_READY, rb: 3'b111,
				ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, dq_oe_n: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	nprc_fifo #(
		.W (8),
		.D (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst_n     (rst_n),
		.i_in_valid  (push),
		.o_in_ready  (fifo_ready),
		.i_in_data   (q.dq3),
		.o_out_valid (o_rd_valid),
		.i_out_ready (i_rd_ready),
		.o_out_data  (o_rd_data)
	);

	assign o_refused = q.refused;
	assign o_timeout = q.tmo;
	assign o_busy    = (q.state != S_IDLE);
	assign o_mode    = q.mode;
	assign o_ce_n    = q.ce_n;
	assign o_cle     = q.cle;
	assign o_ale     = q.ale;
	assign o_we_n    = q.we_n;
	assign o_re_n    = q.re_n;
	assign o_dq_o    = q.dq_o;
	assign o_dq_oe_n = q.dq_oe_n;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	sequence s_fin_30;
		$rose(o_we_n) && o_cle && o_dq_o == `NPRC_CMD_PAGE;
	endsequence
	sequence s_wait_ready;
		##[1:20] q.state == S_WB;
	endsequence

	a_page_wait: assert property (s_fin_30 |-> s_wait_ready)
		else $error("page read confirm not followed by busy wait");
	a_strobe_excl: assert property (!(!o_we_n && !o_re_n))
		else $error("write and read strobes low together");
	a_busy_hold: assert property ((q.state == S_RB && !rb_hi && q.tmr < TMO_C - 16'h0001)
		|=> q.state == S_RB)
		else $error("left busy wait while die busy");
	a_cache_refuse: assert property ((fire && q.mode == M_CACHE && i_req.op == OP_PAGE)
		|=> o_refused && o_req_ready)
		else $error("page read taken in cache-busy state");
	a_mp_refuse: assert property ((fire && q.mode == M_MPCACHE && i_req.op == OP_ROWCHG)
		|=> o_refused)
		else $error("row change taken in multi-plane cache-busy state");
	a_colchg_ok: assert property ((fire && q.mode inside {M_CACHE, M_MPCACHE}
		&& i_req.op == OP_COLCHG && !q.sel_need && !q.restore) |=> !o_refused && o_busy)
		else $error("column change refused during cache output");
	a_sel_gate: assert property ((fire && q.sel_need && i_req.cnt != 16'h0000
		&& !(i_req.op inside {OP_STAT, OP_STENH, OP_COLENH})) |=> o_refused)
		else $error("data read without plane select");
	a_restore_gate: assert property ((fire && q.restore && i_req.cnt != 16'h0000
		&& !(i_req.op inside {OP_STAT, OP_STENH, OP_RMODE, OP_COLCHG, OP_COLENH}))
		|=> o_refused)
		else $error("data read while status output active");
	a_mpq_mode: assert property ((q.state == S_STEP && it.kind == K_END && q.op == OP_MPQ)
		|=> o_mode == M_MPQ)
		else $error("plane queue did not enter queue mode");
	a_cache_mode: assert property ((q.state == S_STEP && it.kind == K_END && q.op == OP_CSEQ
		&& !q.mp) |=> o_mode == M_CACHE)
		else $error("sequential cache read did not enter cache-busy");
endmodule // nprc_host

// *** bench/nprc_die_model.sv ***
/*
 * Behavioural NAND die for the read sequencer bench: command decode, busy timing, cache data.
 * Assumes the bench resolves the shared data bus and hands the resolved level to i_dq.
 */
`timescale 1ns/1ps

module nprc_die_model (
	input  wire logic       i_clk,
	input  wire logic       i_ce_n,
	input  wire logic       i_cle,
	input  wire logic       i_ale,
	input  wire logic       i_we_n,
	input  wire logic       i_re_n,
	input  wire logic [7:0] i_dq,
	output logic [7:0]      o_dq,
	output logic            o_rb_n
);
	localparam int T_PR = 120;
	localparam int T_CB = 40;
	localparam int T_AB = 400;
	localparam int T_SH = 10;
	logic [7:0]  ab[5];
	int          na = 0;
	int          rb_cnt = 0;
	int          ar_cnt = 0;
	int          rb_req = 0;
	int          ar_req = 0;
	logic        go_q = 1'b0;
	logic        stat = 1'b0;
	logic [23:0] cache_row = 24'h000000;
	logic [23:0] data_row = 24'h000000;
	logic [15:0] col = 16'h0000;
	logic [7:0]  last = 8'h00;
	logic [7:0]  prev = 8'h00;

	task automatic go(input int r, input int a);
		rb_req = r;
		ar_req = a;
		go_q = 1'b1;
	endtask

	task automatic do_cmd(input logic [7:0] c);
		logic [23:0] row;
		logic [15:0] cv;
		row = {ab[4], ab[3], ab[2]};
		cv = {ab[1], ab[0]};
		if (rb_cnt != 0 && !(c inside {8'h70, 8'h78, 8'hFF}))
			return;
		if (ar_cnt != 0 && c inside {8'h30, 8'h85})
			return;
		case (c)
		8'h30: begin
			cache_row = row;
			data_row = row;
			col = cv;
			go(T_PR, T_PR);
		end
		// cache reads and plane queue
		// addresses name a page only when they followed 00h, not 85h or 06h
		8'h31: begin
			cache_row = data_row;
			data_row = (na == 5 && prev == 8'h00) ? row : data_row + 24'h000001;
			col = 16'h0000;
			go(T_CB, T_AB);
		end
		8'h32: go(T_SH, T_SH);
		8'h3F: begin
			cache_row = data_row;
			col = 16'h0000;
			go(T_CB, T_CB);
		end
		8'h00: stat = 1'b0;
		8'hE0: begin
			col = cv;
			stat = 1'b0;
		end
		8'h70, 8'h78: stat = 1'b1;
		8'hFF: begin
			stat = 1'b0;
			col = 16'h0000;
			go(T_SH, T_SH);
		end
		default: ;
		endcase
		na = 0;
		prev = c;
	endtask

	always @(posedge i_we_n) begin
		if (i_ce_n === 1'b0 && i_cle === 1'b1)
			do_cmd(i_dq);
		else if (i_ce_n === 1'b0 && i_ale === 1'b1 && na < 5) begin
			ab[na] = i_dq;
			na++;
		end
	end

	always @(negedge i_re_n) begin
		if (i_ce_n === 1'b0) begin
			o_dq = stat ? {1'b1, rb_cnt == 0, rb_cnt == 0 && ar_cnt == 0, 5'h00}
				: cache_row[7:0] ^ col[7:0];
			last = o_dq;
		end
	end

	// released bus must not keep showing the last byte
	always @(posedge i_re_n) begin
		if (i_ce_n === 1'b0 && !stat)
			col++;
		o_dq = ~last;
	end

	always @(posedge i_clk) begin
		if (go_q) begin
			rb_cnt = rb_req;
			ar_cnt = ar_req;
			go_q = 1'b0;
		end else begin
			if (rb_cnt != 0)
				rb_cnt--;
			if (ar_cnt != 0)
				ar_cnt--;
		end
	end

	initial o_dq = 8'hFF;
	// pull-up on the line, so not busy reads high
	assign o_rb_n = (rb_cnt == 0);
endmodule // nprc_die_model

// *** bench/tb.sv ***
/*
 * Self-checking bench of the NAND read sequencer against the behavioural die model.
 * Assumes nprc_pkg, the sequencer and the die model are compiled before it.
 */
`timescale 1ns/1ps

module tb;
	import nprc_pkg::*;
	logic       i_clk;
	logic       i_reset_n;
	logic       i_req_valid;
	logic       i_rd_ready;
	nprc_req_t  i_req;
	nprc_mode_t o_mode;
	logic       o_req_ready, o_refused, o_timeout, o_busy, o_rd_valid;
	logic       o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_dq_oe_n, o_rb;
	logic [7:0] o_rd_data, o_dq_o, die_dq;
	logic [7:0] q[$];
	logic [31:0] seed = 32'h000016FD;
	int         bad_count = 0;
	int         checks_done = 0;
	int         ref_cnt = 0;
	wire logic [7:0] bus = (o_dq_oe_n === 1'b0) ? o_dq_o : die_dq;

	nprc_host #(.PAGE_READ_CYC(200), .FIFO_DEPTH(4)) DUT (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
		.o_req_ready(o_req_ready), .i_req(i_req), .o_refused(o_refused),
		.o_timeout(o_timeout), .o_busy(o_busy), .o_mode(o_mode), .o_rd_valid(o_rd_valid),
		.i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data), .o_ce_n(o_ce_n), .o_cle(o_cle),
		.o_ale(o_ale), .o_we_n(o_we_n), .o_re_n(o_re_n), .o_dq_o(o_dq_o),
		.o_dq_oe_n(o_dq_oe_n), .i_dq(bus), .i_rb_n(o_rb)
	);

	nprc_die_model die (
		.i_clk(i_clk), .i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
		.i_re_n(o_re_n), .i_dq(bus), .o_dq(die_dq), .o_rb_n(o_rb)
	);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic push(input logic [23:0] row, input logic [15:0] col, input int n);
		for (int i = 0; i < n; i++)
			q.push_back(row[7:0] ^ (col[7:0] + 8'(i)));
	endtask

	task automatic run(input nprc_op_t op, input logic [23:0] row, input logic [15:0] col,
			input logic [15:0] cnt, input logic [7:0] ref_exp, input nprc_mode_t m);
		int n;
		int r0;
		n = 0;
		while (o_req_ready !== 1'b1 && n < 5000) begin
			@(negedge i_clk);
			n++;
		end
		chk("ready_wait", 8'(n / 5000), 8'h00);
		r0 = ref_cnt;
		i_req = '{op: op, addr: {row, col}, cnt: cnt};
		i_req_valid = 1'b1;
		@(negedge i_clk);
		i_req_valid = 1'b0;
		repeat (3) @(negedge i_clk);
		n = 0;
		while ((o_busy !== 1'b0 || q.size() != 0) && n < 5000) begin
			@(negedge i_clk);
			n++;
		end
		chk("busy_wait", 8'(n / 5000), 8'h00);
		repeat (2) @(negedge i_clk);
		chk("refused", 8'(ref_cnt - r0), ref_exp);
		chk("mode", {6'h00, o_mode}, {6'h00, m});
		$display("test %s ends, checks %0d bad %0d", op.name(), checks_done, bad_count);
	endtask

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// fifo drain side stalls at random
	always @(negedge i_clk) begin
		logic [31:0] r;
		r = rnd();
		i_rd_ready <= r[0] | r[1];
	end

	always @(posedge i_clk) begin
		if (o_refused === 1'b1)
			ref_cnt++;
		if (o_timeout === 1'b1)
			chk("timeout", 8'h01, 8'h00);
		if (o_rd_valid === 1'b1 && i_rd_ready === 1'b1) begin
			if (q.size() == 0)
				chk("unexpected_byte", 8'h01, 8'h00);
			else
				chk("rd_data", o_rd_data, q.pop_front());
		end
	end

	initial begin
		#200000;
		bad_count++;
		$display("MISMATCH watchdog expected finish seen hang");
		conclude();
	end

	initial begin
		logic [23:0] ra, rc, re;
		logic [15:0] ca, cb;
		i_reset_n = 1'b0;
		i_req_valid = 1'b0;
		i_req = '0;
		i_rd_ready = 1'b0;
		repeat (3) @(negedge i_clk);
		i_reset_n = 1'b1;
		repeat (4) @(negedge i_clk);
		ra = 24'(rnd());
		rc = 24'(rnd());
		re = 24'(rnd());
		ca = {4'h0, 12'(rnd())};
		cb = {4'h0, 12'(rnd())};
		push(ra, ca, 4);
		run(OP_PAGE, ra, ca, 16'h0004, 8'h00, M_READY);
		q.push_back(8'hE0);
		run(OP_STAT, 24'h000000, 16'h0000, 16'h0001, 8'h00, M_READY);
		push(ra, ca + 16'h0004, 2);
		run(OP_RMODE, 24'h000000, 16'h0000, 16'h0002, 8'h00, M_READY);
		run(OP_ROWCHG, 24'(rnd()), cb, 16'h0000, 8'h00, M_READY);
		run(OP_CSEQ, 24'h000000, 16'h0000, 16'h0000, 8'h00, M_CACHE);
		q.push_back(8'hC0);
		run(OP_STAT, 24'h000000, 16'h0000, 16'h0001, 8'h00, M_CACHE);
		q.push_back(8'hC0);
		run(OP_STENH, rc, 16'h0000, 16'h0001, 8'h00, M_CACHE);
		run(OP_CSEQ, 24'h000000, 16'h0000, 16'h0001, 8'h01, M_CACHE);
		push(ra, 16'h0000, 3);
		run(OP_RMODE, 24'h000000, 16'h0000, 16'h0003, 8'h00, M_CACHE);
		run(OP_COLENH, 24'h000000, 16'h0000, 16'h0002, 8'h01, M_CACHE);
		run(OP_PAGE, ra, 16'h0000, 16'h0002, 8'h01, M_CACHE);
		push(ra, cb, 2);
		run(OP_COLCHG, 24'h000000, cb, 16'h0002, 8'h00, M_CACHE);
		push(ra + 24'h000001, 16'h0000, 2);
		run(OP_CRAND, rc, 16'h0000, 16'h0002, 8'h00, M_CACHE);
		push(rc, 16'h0000, 2);
		run(OP_CLAST, 24'h000000, 16'h0000, 16'h0002, 8'h00, M_READY);
		run(OP_MPQ, 24'(rnd()), 16'h0000, 16'h0000, 8'h00, M_MPQ);
		run(OP_PAGE, re, 16'h0000, 16'h0000, 8'h00, M_READY);
		run(OP_CSEQ, 24'h000000, 16'h0000, 16'h0000, 8'h00, M_MPCACHE);
		run(OP_COLCHG, 24'h000000, 16'h0000, 16'h0002, 8'h01, M_MPCACHE);
		run(OP_ROWCHG, re, 16'h0000, 16'h0000, 8'h01, M_MPCACHE);
		push(re, cb, 2);
		run(OP_COLENH, 24'h000000, cb, 16'h0002, 8'h00, M_MPCACHE);
		run(OP_CLAST, 24'h000000, 16'h0000, 16'h0000, 8'h00, M_READY);
		run(OP_RESET, 24'h000000, 16'h0000, 16'h0000, 8'h00, M_READY);
		chk("queue_left", 8'(q.size()), 8'h00);
		conclude();
	end
endmodule // tb
